// ==== sim/cell_link_asserts.sv ====
// Purpose: Link-side checks of the polled cell link.
// Assumes: One link clock for both directions; reset async, active low.
// Notes:   Status promises are tracked for the transmit side only.
`timescale 1ns/1ps
module cell_link_asserts #(
  parameter int AW = cell_link_pkg::ADDR_W
) (
  input  wire logic          I_RST_B,    // async reset, low
  input  wire logic          i_link_clk, // link clock
  input  wire logic [AW-1:0] i_tx_addr,  // transmit poll address
  input  wire logic          i_tx_enb_n, // transmit enable, low
  input  wire logic          i_tx_soc,   // transmit start of cell
  input  wire logic          i_tx_clav,  // transmit status
  input  wire logic          i_rx_enb_n, // receive enable, low
  input  wire logic          i_rx_soc    // receive start of cell
);
  localparam int NP = 1 << AW;
  // ==========================================================================
  // Promise tracking
  logic [AW-1:0] a1_r, a2_r, cur_r;
  logic [NP-1:0] prom_r;
  logic [2:0]    skip_r;
  logic          en_r, chk1_r, chk2_r;
  // A chained cell keeps the port; otherwise the address before the start.
  wire logic [AW-1:0] sel   = en_r ? cur_r : a1_r;
  wire logic          start = i_tx_soc && !i_tx_enb_n;
  // Answers just after a start may be stale, so they set no promise.
  wire logic [NP-1:0] set_v = (i_tx_clav && skip_r == 3'h0) ? NP'(1) << a2_r : '0;
  wire logic [NP-1:0] clr_v = start ? NP'(1) << sel : '0;
  always_ff @(posedge i_link_clk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      a1_r   <= '0;
      a2_r   <= '0;
      cur_r  <= '0;
      prom_r <= '0;
      skip_r <= 3'h0;
      en_r   <= 1'b0;
      chk1_r <= 1'b0;
      chk2_r <= 1'b0;
    end else begin
      a1_r   <= i_tx_addr;
      a2_r   <= a1_r;
      en_r   <= !i_tx_enb_n;
      cur_r  <= start ? sel : cur_r;
      chk1_r <= prom_r[i_tx_addr] && !(start && sel == i_tx_addr);
      chk2_r <= chk1_r;
      skip_r <= start ? 3'h4 : skip_r - {2'h0, skip_r != 3'h0};
      prom_r <= (prom_r | set_v) & ~clr_v;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge i_link_clk); endclocking
  default disable iff (!I_RST_B);
  property p_tx_hold; chk2_r |-> i_tx_clav; endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("tx status dropped early");
  property p_tx_start; $fell(i_tx_enb_n) |-> i_tx_soc; endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx enable without soc");
  property p_tx_enb; i_tx_soc |-> (!i_tx_enb_n) [*8]; endproperty
  a_tx_enb: assert property (p_tx_enb) else $error("tx enable left early");
  property p_tx_len; i_tx_soc |=> (!i_tx_soc) [*8]; endproperty
  a_tx_len: assert property (p_tx_len) else $error("tx cell too short");
  property p_rx_lag; i_rx_soc |-> !$past(i_rx_enb_n, 2); endproperty
  a_rx_lag: assert property (p_rx_lag) else $error("rx soc not after enable");
  property p_rx_start; $fell(i_rx_enb_n) |-> ##2 i_rx_soc; endproperty
  a_rx_start: assert property (p_rx_start) else $error("rx data late");
  property p_rx_pulse; $fell(i_rx_enb_n) |=> i_rx_enb_n; endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx enable held");
  property p_rx_len; i_rx_soc |=> (!i_rx_soc) [*8]; endproperty
  a_rx_len: assert property (p_rx_len) else $error("rx cell too short");
  c_tx: cover property (i_tx_soc);
  c_rx: cover property (i_rx_soc);
  c_chain: cover property (i_tx_soc ##13 i_tx_soc);
  c_hold: cover property (chk2_r && i_tx_clav);
endmodule

// ==== sim/tb_top.sv ====
// Purpose: Bench joining master and port device over the cell link.
// Assumes: User data answers pulls at once with a port and index pattern.
// Notes:   Status maps are raised, then dropped to see traffic stop.
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
  $display("[ERR] %s exp=%0h got=%0h", n, e, g); end end
module tb_top;
  localparam int W = cell_link_pkg::CELL_WORDS;
  logic        clk, rst_b, tx_go, rx_go, pt_v, pt_s, pr_pull, mt_pull, mr_v, mr_s;
  logic [3:0]  room, ready, pr_i, mt_i;
  logic [1:0]  pt_p, pr_p, mt_p, mr_p;
  logic [31:0] pt_d, mr_d, pr_d, mt_d;
  int          checks, failures, cyc, tc, rc, ti, ri, tp, rp;
  cell_link_if lnk ();
  phy_cell_port phy_cell_port_inst (.I_CLK(clk), .I_RST_B(rst_b), .I_TX_ROOM(room),
    .I_RX_READY(ready), .O_TX_VALID(pt_v), .O_TX_SOC(pt_s), .O_TX_PORT(pt_p),
    .O_TX_DATA(pt_d), .O_RX_PULL(pr_pull), .O_RX_PULL_PORT(pr_p), .O_RX_PULL_IDX(pr_i),
    .I_RX_DATA(pr_d), .LINK(lnk.phy_mp));
  atm_cell_master atm_cell_master_inst (.I_CLK(clk), .I_RST_B(rst_b), .I_TX_GO(tx_go),
    .I_RX_GO(rx_go), .O_TX_PULL(mt_pull), .O_TX_PULL_PORT(mt_p), .O_TX_PULL_IDX(mt_i),
    .I_TX_DATA(mt_d), .O_RX_VALID(mr_v), .O_RX_SOC(mr_s), .O_RX_PORT(mr_p),
    .O_RX_DATA(mr_d), .LINK(lnk.atm_mp));
  cell_link_asserts #(.AW(cell_link_pkg::ADDR_W)) cell_link_asserts_inst (
    .I_RST_B(rst_b), .i_link_clk(lnk.link_clk), .i_tx_addr(lnk.tx_addr),
    .i_tx_enb_n(lnk.tx_enb_n), .i_tx_soc(lnk.tx_soc), .i_tx_clav(lnk.tx_clav),
    .i_rx_enb_n(lnk.rx_enb_n), .i_rx_soc(lnk.rx_soc));
  function automatic logic [31:0] pat(input logic [1:0] p, input logic [3:0] i);
    return {16'h5a00, 6'h00, p, 4'h0, i};
  endfunction
  assign pr_d = pat(pr_p, pr_i);
  assign mt_d = pat(mt_p, mt_i);
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    lnk.link_clk = 1'b0;
    #3;
    forever #7.5 lnk.link_clk = ~lnk.link_clk;
  end
  // ==========================================================================
  // Tasks
  task automatic print_verdict;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic word(input string n, input logic s, input logic [1:0] p,
                      input logic [31:0] d, input int ep, inout int i, inout int c);
    if (s) begin
      if (c > 0) `CHK({n, " len"}, W, i)
      i = 0;
      c++;
    end
    `CHK({n, " port"}, ep[1:0], p)
    `CHK({n, " data"}, pat(ep[1:0], i[3:0]), d)
    i++;
  endtask
  task automatic set_maps(input logic [3:0] r, input logic [3:0] q, input int a, input int b);
    @(posedge clk);
    #1;
    room = r;
    ready = q;
    tp = a;
    rp = b;
  endtask
  task automatic until_more(input int n);
    int t0, r0;
    t0 = tc;
    r0 = rc;
    while (tc < t0 + n || rc < r0 + n) @(posedge lnk.link_clk);
  endtask
  task automatic quiet;
    int t0, r0;
    set_maps(4'h0, 4'h0, tp, rp);
    repeat (80) @(posedge lnk.link_clk);
    t0 = tc;
    r0 = rc;
    repeat (80) @(posedge lnk.link_clk);
    `CHK("tx idle", t0, tc)
    `CHK("rx idle", r0, rc)
    `CHK("tx last len", W, ti)
    `CHK("rx last len", W, ri)
  endtask
  // ==========================================================================
  // Monitors, timeout and sequence
  always @(posedge lnk.link_clk) begin
    if (pt_v) word("tx", pt_s, pt_p, pt_d, tp, ti, tc);
    if (mr_v) word("rx", mr_s, mr_p, mr_d, rp, ri, rc);
    if (mt_pull) `CHK("tx pull port", tp[1:0], mt_p)
    if (pr_pull) `CHK("rx pull port", rp[1:0], pr_p)
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    rst_b = 1'b0;
    tx_go = 1'b0;
    rx_go = 1'b0;
    room = 4'h0;
    ready = 4'h0;
    repeat (8) @(posedge clk);
    #1;
    rst_b = 1'b1;
    tx_go = 1'b1;
    rx_go = 1'b1;
    set_maps(4'h4, 4'h8, 2, 3);
    until_more(3);
    quiet();
    set_maps(4'h8, 4'h1, 3, 0);
    until_more(2);
    quiet();
    print_verdict();
  end
endmodule

// ==== src/atm_cell_master.sv ====
// Purpose: Master end: polls every port, selects ports and moves cells.
// Assumes: Go levels arrive on I_CLK; cell words are fetched and delivered
//          on the link clock.
// Notes:   Poll answers are dropped for a short window after each cell
//          start, since answers in flight then may predate the transfer.
`timescale 1ns/1ps
module atm_cell_master #(
  parameter int AW    = cell_link_pkg::ADDR_W,
  parameter int DW    = cell_link_pkg::DATA_W,
  parameter int WORDS = cell_link_pkg::CELL_WORDS
) (
  input  wire logic                     I_CLK,          // user clock
  input  wire logic                     I_RST_B,        // async reset, low
  input  wire logic                     I_TX_GO,        // transmit allowed
  input  wire logic                     I_RX_GO,        // receive allowed
  output logic                          O_TX_PULL,      // word fetch strobe
  output logic [AW-1:0]                 O_TX_PULL_PORT, // port of the cell
  output logic [$clog2(WORDS)-1:0]      O_TX_PULL_IDX,  // word index to fetch
  input  wire logic [DW-1:0]            I_TX_DATA,      // fetched word
  output logic                          O_RX_VALID,     // received word strobe
  output logic                          O_RX_SOC,       // first word of cell
  output logic [AW-1:0]                 O_RX_PORT,      // port of the word
  output logic [DW-1:0]                 O_RX_DATA,      // received word
  cell_link_if.atm_mp                   LINK            // link side
);
  localparam int            NP   = 1 << AW;
  localparam int            IW   = $clog2(WORDS);
  localparam int            SK   = cell_link_pkg::CLAV_SKIP;
  localparam logic [NP-1:0] LSB1 = {{(NP-1){1'b0}}, 1'b1};
  localparam logic [IW-1:0] LAST = IW'(WORDS - 1);

  typedef enum logic [1:0] {T_IDLE, T_SEL, T_SEND} tx_state_type;
  typedef enum logic [1:0] {R_IDLE, R_SEL, R_BUSY} rx_state_type;

  generate
    if (WORDS < cell_link_pkg::MIN_WORDS || AW < 1) begin : g_bad
      $error("atm_cell_master: cell too short or address too narrow");
    end
  endgenerate

  // Lowest numbered port whose bit is set.
  function automatic logic [AW-1:0] first_set(input logic [NP-1:0] v);
    logic [AW-1:0] r;
    r = '0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (v[i]) r = AW'(i);
    end
    return r;
  endfunction

  // ==========================================================================
  // Go levels: registered on I_CLK, then two flops on the link clock.
  logic tx_go_c_r, rx_go_c_r, tx_go_s1_r, tx_go_s2_r, rx_go_s1_r, rx_go_s2_r;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tx_go_c_r <= 1'b0;
      rx_go_c_r <= 1'b0;
    end else begin
      tx_go_c_r <= I_TX_GO;
      rx_go_c_r <= I_RX_GO;
    end
  end

  always_ff @(posedge LINK.link_clk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tx_go_s1_r <= 1'b0;
      tx_go_s2_r <= 1'b0;
      rx_go_s1_r <= 1'b0;
      rx_go_s2_r <= 1'b0;
    end else begin
      tx_go_s1_r <= tx_go_c_r;
      tx_go_s2_r <= tx_go_s1_r;
      rx_go_s1_r <= rx_go_c_r;
      rx_go_s2_r <= rx_go_s1_r;
    end
  end

  // ==========================================================================
  // Link inputs are captured before any logic reads them.
  logic          tx_clav_q_r, rx_clav_q_r, rx_soc_q_r;
  logic [DW-1:0] rx_data_q_r;

  always_ff @(posedge LINK.link_clk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tx_clav_q_r <= 1'b0;
      rx_clav_q_r <= 1'b0;
      rx_soc_q_r  <= 1'b0;
      rx_data_q_r <= '0;
    end else begin
      tx_clav_q_r <= LINK.tx_clav;
      rx_clav_q_r <= LINK.rx_clav;
      rx_soc_q_r  <= LINK.rx_soc;
      rx_data_q_r <= LINK.rx_data;
    end
  end

  // ==========================================================================
  // Transmit: polling, status map and cell sending.
  tx_state_type  tx_state_r, tx_state_nxt;
  logic [AW-1:0] tx_poll_r, tx_addr_r, tx_port_r, tx_p1_r, tx_p2_r, tx_p3_r;
  logic [IW-1:0] tx_idx_r;
  logic [NP-1:0] tx_avail_r;
  logic [SK-1:0] tx_skip_r;
  logic          tx_enb_r, tx_soc_r, tx_begin;
  logic [DW-1:0] tx_data_r;

  wire           tx_last = tx_idx_r == LAST;
  wire           tx_take = (tx_begin || (tx_state_r == T_SEND && !tx_last));
  wire [AW-1:0]  tx_pick = first_set(tx_avail_r);
  wire [NP-1:0]  tx_seen = tx_clav_q_r ? (tx_avail_r | (LSB1 << tx_p3_r))
                                      : (tx_avail_r & ~(LSB1 << tx_p3_r));
  wire [NP-1:0]  tx_rec  = (|tx_skip_r) ? tx_avail_r : tx_seen;

  always_comb begin
    tx_state_nxt = tx_state_r;
    tx_begin     = 1'b0;
    case (tx_state_r)
      T_IDLE: begin
        if (tx_go_s2_r && |tx_avail_r) tx_state_nxt = T_SEL;
      end
      T_SEL: begin
        tx_begin     = 1'b1;
        tx_state_nxt = T_SEND;
      end
      T_SEND: begin
        if (tx_last) begin
          if (tx_go_s2_r && tx_avail_r[tx_port_r]) tx_begin = 1'b1;
          else tx_state_nxt = T_IDLE;
        end
      end
      default: tx_state_nxt = T_IDLE;
    endcase
  end

  assign O_TX_PULL      = tx_take;
  assign O_TX_PULL_PORT = tx_port_r;
  assign O_TX_PULL_IDX  = tx_begin ? '0 : tx_idx_r + 1'b1;

  always_ff @(posedge LINK.link_clk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tx_state_r <= T_IDLE;
      tx_poll_r  <= '0;
      tx_addr_r  <= '0;
      tx_port_r  <= '0;
      tx_p1_r    <= '0;
      tx_p2_r    <= '0;
      tx_p3_r    <= '0;
      tx_idx_r   <= '0;
      tx_avail_r <= '0;
      tx_skip_r  <= '0;
      tx_enb_r   <= cell_link_pkg::ENB_IDLE;
      tx_soc_r   <= 1'b0;
      tx_data_r  <= '0;
    end else begin
      tx_state_r <= tx_state_nxt;
      tx_poll_r  <= tx_poll_r + 1'b1;
      tx_addr_r  <= (tx_state_nxt == T_SEL) ? tx_pick : tx_poll_r;
      tx_port_r  <= (tx_state_nxt == T_SEL) ? tx_pick : tx_port_r;
      tx_p1_r    <= tx_addr_r;
      tx_p2_r    <= tx_p1_r;
      tx_p3_r    <= tx_p2_r;
      tx_idx_r   <= tx_begin ? '0 : tx_idx_r + 1'b1;
      tx_avail_r <= tx_begin ? (tx_rec & ~(LSB1 << tx_port_r)) : tx_rec;
      tx_skip_r  <= {tx_skip_r[SK-2:0], tx_begin};
      tx_enb_r   <= !tx_take;
      tx_soc_r   <= tx_begin;
      tx_data_r  <= tx_take ? I_TX_DATA : '0;
    end
  end

  // ==========================================================================
  // Receive: polling, status map, enable pulses and word capture.
  rx_state_type  rx_state_r, rx_state_nxt;
  logic [AW-1:0] rx_poll_r, rx_addr_r, rx_port_r, rx_p1_r, rx_p2_r, rx_p3_r;
  logic [IW-1:0] rx_cnt_r, rx_in_idx_r;
  logic [NP-1:0] rx_avail_r;
  logic [SK-1:0] rx_skip_r;
  logic          rx_enb_r, rx_begin, rx_in_busy_r;

  wire           rx_in_more = rx_in_busy_r && rx_in_idx_r != LAST;
  wire [AW-1:0]  rx_pick    = first_set(rx_avail_r);
  wire [NP-1:0]  rx_seen    = rx_clav_q_r ? (rx_avail_r | (LSB1 << rx_p3_r))
                                         : (rx_avail_r & ~(LSB1 << rx_p3_r));
  wire [NP-1:0]  rx_rec     = (|rx_skip_r) ? rx_avail_r : rx_seen;

  always_comb begin
    rx_state_nxt = rx_state_r;
    rx_begin     = 1'b0;
    case (rx_state_r)
      R_IDLE: begin
        if (rx_go_s2_r && |rx_avail_r) rx_state_nxt = R_SEL;
      end
      R_SEL: begin
        rx_begin     = 1'b1;
        rx_state_nxt = R_BUSY;
      end
      R_BUSY: begin
        if (rx_cnt_r == LAST) begin
          if (rx_go_s2_r && rx_avail_r[rx_port_r]) rx_begin = 1'b1;
          else rx_state_nxt = R_IDLE;
        end
      end
      default: rx_state_nxt = R_IDLE;
    endcase
  end

  always_ff @(posedge LINK.link_clk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rx_state_r   <= R_IDLE;
      rx_poll_r    <= '0;
      rx_addr_r    <= '0;
      rx_port_r    <= '0;
      rx_p1_r      <= '0;
      rx_p2_r      <= '0;
      rx_p3_r      <= '0;
      rx_cnt_r     <= '0;
      rx_avail_r   <= '0;
      rx_skip_r    <= '0;
      rx_enb_r     <= cell_link_pkg::ENB_IDLE;
      rx_in_idx_r  <= '0;
      rx_in_busy_r <= 1'b0;
      O_RX_VALID   <= 1'b0;
      O_RX_SOC     <= 1'b0;
      O_RX_PORT    <= '0;
      O_RX_DATA    <= '0;
    end else begin
      rx_state_r   <= rx_state_nxt;
      rx_poll_r    <= rx_poll_r + 1'b1;
      rx_addr_r    <= (rx_state_nxt == R_SEL) ? rx_pick : rx_poll_r;
      rx_port_r    <= (rx_state_nxt == R_SEL) ? rx_pick : rx_port_r;
      rx_p1_r      <= rx_addr_r;
      rx_p2_r      <= rx_p1_r;
      rx_p3_r      <= rx_p2_r;
      rx_cnt_r     <= rx_begin ? '0 : rx_cnt_r + 1'b1;
      rx_avail_r   <= rx_begin ? (rx_rec & ~(LSB1 << rx_port_r)) : rx_rec;
      rx_skip_r    <= {rx_skip_r[SK-2:0], rx_begin};
      rx_enb_r     <= !rx_begin;
      rx_in_idx_r  <= rx_soc_q_r ? '0 : (rx_in_more ? rx_in_idx_r + 1'b1 : rx_in_idx_r);
      rx_in_busy_r <= rx_soc_q_r || rx_in_more;
      O_RX_VALID   <= rx_soc_q_r || rx_in_more;
      O_RX_SOC     <= rx_soc_q_r;
      O_RX_PORT    <= rx_soc_q_r ? rx_port_r : O_RX_PORT;
      O_RX_DATA    <= rx_data_q_r;
    end
  end

  assign LINK.tx_addr  = tx_addr_r;
  assign LINK.tx_enb_n = tx_enb_r;
  assign LINK.tx_soc   = tx_soc_r;
  assign LINK.tx_data  = tx_data_r;
  assign LINK.rx_addr  = rx_addr_r;
  assign LINK.rx_enb_n = rx_enb_r;
endmodule

// ==== src/cell_link_if.sv ====
// Purpose: Wires of the polled cell link between master and port device.
// Assumes: The bench drives link_clk; enables are active low.
// Notes:   Each party drives only the signals its modport lists as outputs.
`timescale 1ns/1ps
interface cell_link_if #(
  parameter int AW = cell_link_pkg::ADDR_W,
  parameter int DW = cell_link_pkg::DATA_W
);
  logic          link_clk;
  logic [AW-1:0] tx_addr;
  logic          tx_enb_n;
  logic          tx_soc;
  logic [DW-1:0] tx_data;
  logic          tx_clav;
  logic [AW-1:0] rx_addr;
  logic          rx_enb_n;
  logic          rx_soc;
  logic [DW-1:0] rx_data;
  logic          rx_clav;

  modport phy_mp (
    input  link_clk, tx_addr, tx_enb_n, tx_soc, tx_data, rx_addr, rx_enb_n,
    output tx_clav, rx_soc, rx_data, rx_clav
  );

  modport atm_mp (
    input  link_clk, tx_clav, rx_soc, rx_data, rx_clav,
    output tx_addr, tx_enb_n, tx_soc, tx_data, rx_addr, rx_enb_n
  );
endinterface

// ==== src/cell_link_pkg.sv ====
// Purpose: Shared constants of the polled multi-port cell link.
// Assumes: One status line per direction, ports polled by address.
// Notes:   Cell length is counted in bus words of the configured width.
package cell_link_pkg;

  // ==========================================================================
  // Widths and cell framing
  localparam int ADDR_W     = 2;
  localparam int DATA_W     = 32;
  localparam int CELL_BYTES = 52;
  localparam int CELL_WORDS = CELL_BYTES / (DATA_W / 8);

  // ==========================================================================
  // Timing counts in link clock cycles, and the minimum cell length in words
  localparam int POLL_DELAY = 2;
  localparam int RX_DELAY   = 2;
  localparam int CLAV_SKIP  = 4;
  localparam int MIN_WORDS  = 4;

  // ==========================================================================
  // Reset and idle levels
  localparam logic ENB_IDLE = 1'b1;

endpackage

// ==== src/phy_cell_port.sv ====
// Purpose: Port device end: answers polls and moves cells for all ports.
// Assumes: Room and ready maps arrive on I_CLK; the cell data side runs
//          on the link clock.
// Notes:   Once a port answers available it keeps doing so until its cell
//          has started, even if the user map drops earlier.
`timescale 1ns/1ps
module phy_cell_port #(
  parameter int AW    = cell_link_pkg::ADDR_W,
  parameter int DW    = cell_link_pkg::DATA_W,
  parameter int WORDS = cell_link_pkg::CELL_WORDS
) (
  input  wire logic                     I_CLK,          // user clock
  input  wire logic                     I_RST_B,        // async reset, low
  input  wire logic [(1<<AW)-1:0]       I_TX_ROOM,      // port can take a cell
  input  wire logic [(1<<AW)-1:0]       I_RX_READY,     // port holds a cell
  output logic                          O_TX_VALID,     // received word strobe
  output logic                          O_TX_SOC,       // first word of cell
  output logic [AW-1:0]                 O_TX_PORT,      // port of the word
  output logic [DW-1:0]                 O_TX_DATA,      // received word
  output logic                          O_RX_PULL,      // word fetch strobe
  output logic [AW-1:0]                 O_RX_PULL_PORT, // port to fetch from
  output logic [$clog2(WORDS)-1:0]      O_RX_PULL_IDX,  // word index to fetch
  input  wire logic [DW-1:0]            I_RX_DATA,      // fetched word
  cell_link_if.phy_mp                   LINK            // link side
);
  localparam int              NP   = 1 << AW;
  localparam int              IW   = $clog2(WORDS);
  localparam logic [NP-1:0]   LSB1 = {{(NP-1){1'b0}}, 1'b1};
  localparam logic [IW-1:0]   LAST = IW'(WORDS - 1);

  generate
    if (WORDS < cell_link_pkg::MIN_WORDS || AW < 1) begin : g_bad
      $error("phy_cell_port: cell too short or address too narrow");
    end
  endgenerate

  // ==========================================================================
  // User maps: registered on I_CLK, then two flops on the link clock.
  logic [NP-1:0] room_c_r, ready_c_r, room_s1_r, room_s2_r, ready_s1_r, ready_s2_r;

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      room_c_r  <= '0;
      ready_c_r <= '0;
    end else begin
      room_c_r  <= I_TX_ROOM;
      ready_c_r <= I_RX_READY;
    end
  end

  always_ff @(posedge LINK.link_clk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      room_s1_r  <= '0;
      room_s2_r  <= '0;
      ready_s1_r <= '0;
      ready_s2_r <= '0;
    end else begin
      room_s1_r  <= room_c_r;
      room_s2_r  <= room_s1_r;
      ready_s1_r <= ready_c_r;
      ready_s2_r <= ready_s1_r;
    end
  end

  // ==========================================================================
  // Link inputs are captured before use; addresses keep two cycles.
  logic [AW-1:0] tx_addr_q_r, tx_addr_qq_r, rx_addr_q_r, rx_addr_qq_r;
  logic          tx_enb_q_r, tx_enb_qq_r, tx_soc_q_r, rx_enb_q_r, rx_enb_qq_r;
  logic [DW-1:0] tx_data_q_r;

  always_ff @(posedge LINK.link_clk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tx_addr_q_r  <= '0;
      tx_addr_qq_r <= '0;
      rx_addr_q_r  <= '0;
      rx_addr_qq_r <= '0;
      tx_enb_q_r   <= cell_link_pkg::ENB_IDLE;
      tx_enb_qq_r  <= cell_link_pkg::ENB_IDLE;
      rx_enb_q_r   <= cell_link_pkg::ENB_IDLE;
      rx_enb_qq_r  <= cell_link_pkg::ENB_IDLE;
      tx_soc_q_r   <= 1'b0;
      tx_data_q_r  <= '0;
    end else begin
      tx_addr_q_r  <= LINK.tx_addr;
      tx_addr_qq_r <= tx_addr_q_r;
      rx_addr_q_r  <= LINK.rx_addr;
      rx_addr_qq_r <= rx_addr_q_r;
      tx_enb_q_r   <= LINK.tx_enb_n;
      tx_enb_qq_r  <= tx_enb_q_r;
      rx_enb_q_r   <= LINK.rx_enb_n;
      rx_enb_qq_r  <= rx_enb_q_r;
      tx_soc_q_r   <= LINK.tx_soc;
      tx_data_q_r  <= LINK.tx_data;
    end
  end

  // ==========================================================================
  // Transmit: selection, word counting and poll answers.
  logic [AW-1:0] tx_port_r;
  logic [IW-1:0] tx_idx_r;
  logic          tx_busy_r, tx_clav_r;
  logic [NP-1:0] tx_prom_r;

  wire           tx_word   = !tx_enb_q_r;
  wire           tx_start  = tx_word && tx_soc_q_r;
  wire           tx_more   = tx_word && !tx_soc_q_r && tx_busy_r;
  wire [AW-1:0]  tx_port_n = (tx_start && tx_enb_qq_r) ? tx_addr_qq_r : tx_port_r;
  wire [NP-1:0]  tx_clr    = (tx_more && tx_idx_r == '0) ? (LSB1 << tx_port_r) : '0;
  wire [NP-1:0]  tx_keep   = tx_prom_r & ~tx_clr;
  wire           tx_ans    = room_s2_r[tx_addr_q_r] | tx_keep[tx_addr_q_r];

  always_ff @(posedge LINK.link_clk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      tx_port_r  <= '0;
      tx_idx_r   <= '0;
      tx_busy_r  <= 1'b0;
      tx_clav_r  <= 1'b0;
      tx_prom_r  <= '0;
      O_TX_VALID <= 1'b0;
      O_TX_SOC   <= 1'b0;
      O_TX_PORT  <= '0;
      O_TX_DATA  <= '0;
    end else begin
      tx_port_r  <= tx_port_n;
      tx_idx_r   <= tx_start ? '0 : (tx_more ? tx_idx_r + 1'b1 : tx_idx_r);
      tx_busy_r  <= tx_start || (tx_busy_r && !(tx_more && tx_idx_r == LAST - 1'b1));
      tx_clav_r  <= tx_ans;
      tx_prom_r  <= tx_keep | (tx_ans ? (LSB1 << tx_addr_q_r) : '0);
      O_TX_VALID <= tx_start || tx_more;
      O_TX_SOC   <= tx_start;
      O_TX_PORT  <= tx_port_n;
      O_TX_DATA  <= tx_data_q_r;
    end
  end

  // ==========================================================================
  // Receive: data follows the enable by two cycles; idle keeps zeros.
  logic [AW-1:0] rx_port_r;
  logic [IW-1:0] rx_idx_r;
  logic          rx_busy_r, rx_clav_r, rx_soc_r;
  logic [DW-1:0] rx_data_r;
  logic [NP-1:0] rx_prom_r;

  wire           rx_last   = rx_idx_r == LAST;
  wire           rx_go     = !rx_enb_q_r && (!rx_busy_r || rx_last);
  wire           rx_send   = rx_go || (rx_busy_r && !rx_last);
  wire [AW-1:0]  rx_port_n = (!rx_busy_r && rx_enb_qq_r) ? rx_addr_qq_r : rx_port_r;
  wire [IW-1:0]  rx_idx_n  = rx_go ? '0 : (rx_send ? rx_idx_r + 1'b1 : rx_idx_r);
  wire [NP-1:0]  rx_keep   = rx_prom_r & ~(rx_go ? (LSB1 << rx_port_n) : '0);
  wire           rx_ans    = ready_s2_r[rx_addr_q_r] | rx_keep[rx_addr_q_r];

  assign O_RX_PULL      = rx_send;
  assign O_RX_PULL_PORT = rx_port_n;
  assign O_RX_PULL_IDX  = rx_idx_n;

  always_ff @(posedge LINK.link_clk or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rx_port_r <= '0;
      rx_idx_r  <= '0;
      rx_busy_r <= 1'b0;
      rx_clav_r <= 1'b0;
      rx_soc_r  <= 1'b0;
      rx_data_r <= '0;
      rx_prom_r <= '0;
    end else begin
      rx_port_r <= rx_port_n;
      rx_idx_r  <= rx_idx_n;
      rx_busy_r <= rx_send;
      rx_clav_r <= rx_ans;
      rx_soc_r  <= rx_go;
      rx_data_r <= rx_send ? I_RX_DATA : '0;
      rx_prom_r <= rx_keep | (rx_ans ? (LSB1 << rx_addr_q_r) : '0);
    end
  end

  assign LINK.tx_clav = tx_clav_r;
  assign LINK.rx_clav = rx_clav_r;
  assign LINK.rx_soc  = rx_soc_r;
  assign LINK.rx_data = rx_data_r;
endmodule
